// >>> src/lpw_regs.svh
`ifndef LPW_REGS_SVH
`define LPW_REGS_SVH
// -----------------------------------------------------------------
// byte locations and defaults
// -----------------------------------------------------------------
`define LPW_WEN_ADDR 8'hc1
`define LPW_REN_ADDR 8'hc2
`define LPW_PW_FIRST 8'hc3
`define LPW_PW_LAST 8'hc6
`define LPW_TDEF_ADDR 8'hc7
`define LPW_ENTRY_FIRST 8'h7b
`define LPW_ENTRY_LAST 8'h7e
`define LPW_TSEL_ADDR 8'h7f
`define LPW_WEN_RST 8'h00
`define LPW_REN_RST 8'h00
`define LPW_PW_RST 32'h0000_0000
`define LPW_TDEF_RST 8'h01
`define LPW_LOCKED_VAL 8'h00
// -----------------------------------------------------------------
// table numbers
// -----------------------------------------------------------------
`define LPW_TBL_00 8'h00
`define LPW_TBL_01 8'h01
`define LPW_TBL_02 8'h02
`define LPW_TBL_03 8'h03
`define LPW_TBL_04 8'h04
`define LPW_TBL_05 8'h05
// -----------------------------------------------------------------
// enable bit positions, one per guarded block
// -----------------------------------------------------------------
`define LPW_B_DEVCTL 7
`define LPW_B_MASK5 6
`define LPW_B_CFG 5
`define LPW_B_UTOP 4
`define LPW_B_USER 3
`define LPW_B_LOWER 2
`define LPW_B_AUXHI 1
`define LPW_B_AUXLO 0
`endif

// >>> src/lpw_pkg.sv
`default_nettype none
package lpw_pkg;
  // gray coded: load -> idle -> answer -> idle
  typedef enum logic [1:0] {
    LPW_ST_LOAD = 2'b00,
    LPW_ST_IDLE = 2'b01,
    LPW_ST_ANS = 2'b11
  } lpw_state_t;

  typedef struct packed {
    lpw_state_t st;
    logic [7:0] wen;
    logic [7:0] ren;
    logic [31:0] pw;
    logic [31:0] entry;
    logic [7:0] tsel;
    logic [7:0] tdef;
    logic ack;
    logic grant;
    logic mem_wr;
    logic [7:0] rdata;
  } lpw_state_regs_t;
endpackage
`default_nettype wire

// >>> src/lpw_top.sv
`include "lpw_regs.svh"
`default_nettype none
module lpw_top
  import lpw_pkg::*;
#(
  parameter int PW_BYTES = 4
) (
  input wire logic clk_i, // 10 MHz system clock
  input wire logic rstn_i, // synchronous reset, active low
  input wire logic alt_map_i, // alternate table configuration
  input wire logic acc_req_i, // one-cycle byte access request
  input wire logic acc_wr_i, // 1 = write, 0 = read
  input wire logic acc_aux_i, // 1 = auxiliary memory, 0 = main
  input wire logic [7:0] acc_addr_i, // byte address
  input wire logic [7:0] acc_wdata_i, // write byte
  input wire logic [7:0] mem_rdata_i, // backing memory read byte
  output logic acc_ack_o, // one-cycle answer
  output logic acc_grant_o, // access allowed
  output logic [7:0] acc_rdata_o, // read byte
  output logic mem_wr_o, // write strobe to backing memory
  output logic [7:0] tbl_sel_o // current table select
);
  // -----------------------------------------------------------------
  // elaboration check
  // -----------------------------------------------------------------
  if (PW_BYTES != 4) begin : g_bad_pw
    $error("password width other than four bytes is not supported");
  end

  lpw_state_regs_t s_reg;
  lpw_state_regs_t s_next;
  logic [7:0] cfg_tbl;
  logic [7:0] usr_tbl;
  logic [7:0] hit;
  logic unlocked;
  logic in_cfg;
  logic w_prot;
  logic r_prot;
  logic [1:0] bidx;

  // alternate configuration moves the config table from 04 to 01 and the user table from 01 to 00
  assign cfg_tbl = alt_map_i ? `LPW_TBL_01 : `LPW_TBL_04;
  assign usr_tbl = alt_map_i ? `LPW_TBL_00 : `LPW_TBL_01;
  assign unlocked = (s_reg.entry == s_reg.pw);
  assign in_cfg = !acc_aux_i && acc_addr_i[7] && (s_reg.tsel == cfg_tbl);
  assign bidx = 2'(acc_addr_i - `LPW_PW_FIRST);

  // -----------------------------------------------------------------
  // block decode: which enable bits cover the addressed byte
  // -----------------------------------------------------------------
  always_comb begin
    hit = 8'h00;
    if (acc_aux_i) begin
      hit[`LPW_B_AUXHI] = acc_addr_i[7];
      hit[`LPW_B_AUXLO] = !acc_addr_i[7];
    end else if (!acc_addr_i[7]) begin
      hit[`LPW_B_LOWER] = (acc_addr_i <= 8'h7a);
    end else begin
      hit[`LPW_B_DEVCTL] = (s_reg.tsel == `LPW_TBL_05) &&
        (acc_addr_i >= 8'hd0) && (acc_addr_i <= 8'hd6);
      hit[`LPW_B_MASK5] = (s_reg.tsel == `LPW_TBL_05) && (acc_addr_i >= 8'hf8);
      hit[`LPW_B_CFG] = (acc_addr_i <= 8'hc7) && ((s_reg.tsel == cfg_tbl) ||
        (s_reg.tsel == `LPW_TBL_02) || (s_reg.tsel == `LPW_TBL_03));
      hit[`LPW_B_UTOP] = (s_reg.tsel == usr_tbl) && (acc_addr_i >= 8'hf8);
      hit[`LPW_B_USER] = (s_reg.tsel == usr_tbl) && (acc_addr_i <= 8'hf7);
    end
  end

  // a set bit protects, a clear bit leaves the block open
  assign w_prot = |(hit & s_reg.wen) && !unlocked;
  assign r_prot = |(hit & s_reg.ren) && !unlocked;

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.ack = 1'b0;
    s_next.mem_wr = 1'b0;
    case (s_reg.st)
      LPW_ST_LOAD: begin
        // power-up copy of the default table select
        s_next.tsel = s_reg.tdef;
        s_next.st = LPW_ST_IDLE;
      end
      LPW_ST_IDLE: begin
        if (acc_req_i) begin
          s_next.st = LPW_ST_ANS;
          s_next.ack = 1'b1;
          s_next.grant = acc_wr_i ? !w_prot : !r_prot;
          s_next.rdata = `LPW_LOCKED_VAL;
          if (acc_wr_i) begin
            if (!w_prot) begin
              // only writes that pass the guard reach here; locked writes change nothing
              if (in_cfg && acc_addr_i == `LPW_WEN_ADDR) begin
                s_next.wen = acc_wdata_i;
              end else if (in_cfg && acc_addr_i == `LPW_REN_ADDR) begin
                s_next.ren = acc_wdata_i;
              end else if (in_cfg && acc_addr_i >= `LPW_PW_FIRST &&
                           acc_addr_i <= `LPW_PW_LAST) begin
                s_next.pw[8*(3-bidx) +: 8] = acc_wdata_i;
              end else if (in_cfg && acc_addr_i == `LPW_TDEF_ADDR) begin
                s_next.tdef = acc_wdata_i;
              end else if (!acc_aux_i && acc_addr_i >= `LPW_ENTRY_FIRST &&
                           acc_addr_i <= `LPW_ENTRY_LAST) begin
                s_next.entry[8*(3-2'(acc_addr_i - `LPW_ENTRY_FIRST)) +: 8] =
                  acc_wdata_i;
              end else if (!acc_aux_i && acc_addr_i == `LPW_TSEL_ADDR) begin
                s_next.tsel = acc_wdata_i;
              end else begin
                s_next.mem_wr = 1'b1;
              end
            end
          end else if (!r_prot) begin
            if (in_cfg && acc_addr_i == `LPW_WEN_ADDR) begin
              s_next.rdata = s_reg.wen;
            end else if (in_cfg && acc_addr_i == `LPW_REN_ADDR) begin
              s_next.rdata = s_reg.ren;
            end else if (in_cfg && acc_addr_i >= `LPW_PW_FIRST &&
                         acc_addr_i <= `LPW_PW_LAST) begin
              // password stays hidden until the entry matches
              s_next.rdata = unlocked ? s_reg.pw[8*(3-bidx) +: 8] : `LPW_LOCKED_VAL;
            end else if (in_cfg && acc_addr_i == `LPW_TDEF_ADDR) begin
              s_next.rdata = s_reg.tdef;
            end else if (!acc_aux_i && acc_addr_i >= `LPW_ENTRY_FIRST &&
                         acc_addr_i <= `LPW_ENTRY_LAST) begin
              s_next.rdata = `LPW_LOCKED_VAL; // entry is write-only
            end else if (!acc_aux_i && acc_addr_i == `LPW_TSEL_ADDR) begin
              s_next.rdata = s_reg.tsel;
            end else begin
              s_next.rdata = mem_rdata_i;
            end
          end
        end
      end
      LPW_ST_ANS: begin
        // one idle turn between answers keeps requests single-cycle
        s_next.st = LPW_ST_IDLE;
      end
      default: begin
        s_next.st = LPW_ST_IDLE;
      end
    endcase
  end

  // -----------------------------------------------------------------
  // state register
  // -----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      s_reg.st <= LPW_ST_LOAD;
      s_reg.wen <= `LPW_WEN_RST;
      s_reg.ren <= `LPW_REN_RST;
      s_reg.pw <= `LPW_PW_RST;
      s_reg.entry <= 32'hffff_ffff;
      s_reg.tsel <= `LPW_TDEF_RST;
      s_reg.tdef <= `LPW_TDEF_RST;
      s_reg.ack <= 1'b0;
      s_reg.grant <= 1'b0;
      s_reg.mem_wr <= 1'b0;
      s_reg.rdata <= 8'h00;
    end else begin
      s_reg <= s_next;
    end
  end

  assign acc_ack_o = s_reg.ack;
  assign acc_grant_o = s_reg.grant;
  assign acc_rdata_o = s_reg.rdata;
  assign mem_wr_o = s_reg.mem_wr;
  assign tbl_sel_o = s_reg.tsel;

  // -----------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------
  logic take;
  assign take = (s_reg.st == LPW_ST_IDLE) && acc_req_i;

  property p_locked_write;
    @(posedge clk_i) disable iff (!rstn_i)
      take && acc_wr_i && w_prot |=> !mem_wr_o && !acc_grant_o && acc_ack_o;
  endproperty
  a_locked_write: assert property (p_locked_write)
    else $error("locked write let through");

  property p_wen_kept;
    @(posedge clk_i) disable iff (!rstn_i)
      take && acc_wr_i && w_prot |=> $stable(s_reg.wen) && $stable(s_reg.pw);
  endproperty
  a_wen_kept: assert property (p_wen_kept)
    else $error("locked write changed a setting");

  property p_locked_read;
    @(posedge clk_i) disable iff (!rstn_i)
      take && !acc_wr_i && r_prot |=> acc_rdata_o == `LPW_LOCKED_VAL && !acc_grant_o;
  endproperty
  a_locked_read: assert property (p_locked_read)
    else $error("locked read exposed data");

  // load lasts one cycle, so a request may already be taken on the next edge
  property p_load;
    @(posedge clk_i) disable iff (!rstn_i)
      s_reg.st == LPW_ST_LOAD |=> tbl_sel_o == $past(s_reg.tdef) && s_reg.st == LPW_ST_IDLE;
  endproperty
  a_load: assert property (p_load)
    else $error("table select not loaded");

  property p_open;
    @(posedge clk_i) disable iff (!rstn_i)
      take && s_reg.wen == 8'h00 && s_reg.ren == 8'h00 |=> acc_grant_o;
  endproperty
  a_open: assert property (p_open)
    else $error("open block refused");

  property p_devctl;
    @(posedge clk_i) disable iff (!rstn_i)
      take && acc_wr_i && !acc_aux_i && s_reg.tsel == `LPW_TBL_05 && acc_addr_i == 8'hd6 &&
      s_reg.wen[`LPW_B_DEVCTL] && !unlocked |=> !acc_grant_o;
  endproperty
  a_devctl: assert property (p_devctl)
    else $error("block D0h..D6h not guarded");

  property p_mask5;
    @(posedge clk_i) disable iff (!rstn_i)
      take && acc_wr_i && !acc_aux_i && s_reg.tsel == `LPW_TBL_05 && acc_addr_i == 8'hf8 &&
      s_reg.wen[`LPW_B_MASK5] && !unlocked |=> !mem_wr_o;
  endproperty
  a_mask5: assert property (p_mask5)
    else $error("block F8h..FFh not guarded");

  property p_lower;
    @(posedge clk_i) disable iff (!rstn_i)
      take && !acc_wr_i && !acc_aux_i && acc_addr_i == 8'h7a &&
      s_reg.ren[`LPW_B_LOWER] && !unlocked |=> acc_rdata_o == `LPW_LOCKED_VAL;
  endproperty
  a_lower: assert property (p_lower)
    else $error("lower block read not guarded");

  property p_auxlo;
    @(posedge clk_i) disable iff (!rstn_i)
      take && acc_wr_i && acc_aux_i && !acc_addr_i[7] &&
      s_reg.wen[`LPW_B_AUXLO] && !unlocked |=> !acc_grant_o ##1 !acc_ack_o;
  endproperty
  a_auxlo: assert property (p_auxlo)
    else $error("aux low block not guarded");

  property p_pw_hidden;
    @(posedge clk_i) disable iff (!rstn_i)
      take && !acc_wr_i && in_cfg && acc_addr_i == `LPW_PW_FIRST && !unlocked
      |=> acc_rdata_o == `LPW_LOCKED_VAL;
  endproperty
  a_pw_hidden: assert property (p_pw_hidden)
    else $error("password byte exposed");
endmodule
`default_nettype wire

// >>> bench/lpw_host_model.sv
`default_nettype none
module lpw_host_model (
  input wire logic clk_i, // system clock
  input wire logic ack_i, // answer strobe
  input wire logic grant_i, // access allowed
  input wire logic [7:0] rdata_i, // read byte
  output logic req_o, // access request
  output logic wr_o, // 1 = write
  output logic aux_o, // auxiliary memory select
  output logic [7:0] addr_o, // byte address
  output logic [7:0] wdata_o // write byte
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus at time zero
  initial begin
    req_o = 1'b0;
    wr_o = 1'b0;
    aux_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 8'h00;
  end
  // request held through the answer edge, the guard ignores it in the answer cycle;
  // released lines show the inverse so a stale value is never mistaken for data
  task automatic xfer(input logic w, input logic a, input logic [7:0] ad,
                      input logic [7:0] wd, output logic gr, output logic [7:0] rd);
    int n;
    n = 0;
    @(posedge clk_i);
    #1;
    {req_o, wr_o, aux_o, addr_o, wdata_o} = {1'b1, w, a, ad, wd};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_i !== 1'b1 && n < 8);
    gr = (ack_i === 1'b1) ? grant_i : 1'bx;
    rd = rdata_i;
    #1;
    {req_o, wr_o, aux_o, addr_o, wdata_o} = {1'b0, ~w, ~a, ~ad, ~wd};
  endtask
  // present a password through the four entry bytes, most significant first
  task automatic enter(input logic [31:0] pw);
    logic g;
    logic [7:0] r;
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, 1'b0, 8'h7b + 8'(i), pw[31 - 8 * i -: 8], g, r);
    end
  endtask
endmodule
`default_nettype wire

// >>> bench/testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i;
  logic rstn_i;
  logic alt_map_i;
  logic acc_req, acc_wr, acc_aux, acc_ack, acc_grant, mem_wr, g;
  logic [7:0] acc_addr, acc_wdata, mem_rdata, acc_rdata, tbl_sel, r, b, a, t, ia, oa;
  logic [7:0] mem [512];
  int miscompares = 0;
  int num_checks = 0;
  // bit, map (bit0 auxiliary, bit1 alternate), table, inside, outside
  logic [39:0] blk [9] = '{
    40'h00_01_01_7f_80, 40'h01_01_01_80_7f, 40'h02_00_01_7a_80, 40'h03_00_01_80_f8,
    40'h04_00_01_ff_f7, 40'h05_00_02_c7_c8, 40'h06_00_05_f8_f7, 40'h07_00_05_d6_d7,
    40'h05_02_01_80_c8};
  // -----------------------------------------------------------------
  // clock, backing memory, instances
  // -----------------------------------------------------------------
  always #50 clk_i = ~clk_i;
  function automatic logic [7:0] ini(input logic [7:0] i);
    return i ^ 8'h5a;
  endfunction
  // memory keeps its own copy; out-of-block writes store the same value again
  initial foreach (mem[i]) mem[i] = ini(8'(i));
  assign mem_rdata = mem[{acc_aux, acc_addr}];
  always @(posedge clk_i) if (mem_wr === 1'b1) mem[{acc_aux, acc_addr}] <= acc_wdata;
  lpw_host_model i_lpw_host_model (.clk_i(clk_i), .ack_i(acc_ack), .grant_i(acc_grant),
    .rdata_i(acc_rdata), .req_o(acc_req), .wr_o(acc_wr), .aux_o(acc_aux),
    .addr_o(acc_addr), .wdata_o(acc_wdata));
  lpw_top i_lpw_top (.clk_i(clk_i), .rstn_i(rstn_i), .alt_map_i(alt_map_i),
    .acc_req_i(acc_req), .acc_wr_i(acc_wr), .acc_aux_i(acc_aux), .acc_addr_i(acc_addr),
    .acc_wdata_i(acc_wdata), .mem_rdata_i(mem_rdata), .acc_ack_o(acc_ack),
    .acc_grant_o(acc_grant), .acc_rdata_o(acc_rdata), .mem_wr_o(mem_wr),
    .tbl_sel_o(tbl_sel));
  // -----------------------------------------------------------------
  // checking and access tasks
  // -----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one access; grant always compared, read byte compared on reads only
  task automatic acc(input logic w, input logic x, input logic [7:0] ad,
                     input logic [7:0] wd, input logic eg, input logic [7:0] er);
    i_lpw_host_model.xfer(w, x, ad, wd, g, r);
    chk({7'h00, g}, {7'h00, eg});
    if (!w) begin
      chk(r, er);
    end
  endtask
  task automatic give_verdict();
    if (miscompares == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // -----------------------------------------------------------------
  // tests
  // -----------------------------------------------------------------
  // watchdog: the sequence needs well under 2000 cycles
  initial begin
    #1_000_000;
    miscompares++;
    give_verdict();
  end
  initial begin
    clk_i = 1'b0;
    rstn_i = 1'b0;
    alt_map_i = 1'b0;
    repeat (4) @(posedge clk_i);
    #1 rstn_i = 1'b1;
    repeat (2) @(posedge clk_i);
    chk(tbl_sel, 8'h01);
    acc(1'b1, 1'b0, 8'h7f, 8'h04, 1'b1, 8'h00);
    chk(tbl_sel, 8'h04);
    acc(1'b0, 1'b0, 8'hc1, 8'h00, 1'b1, 8'h00);
    acc(1'b0, 1'b0, 8'hc2, 8'h00, 1'b1, 8'h00);
    i_lpw_host_model.enter(32'h0000_0000);
    for (int i = 0; i < 4; i++) acc(1'b0, 1'b0, 8'hc3 + 8'(i), 8'h00, 1'b1, 8'h00);
    for (int i = 0; i < 4; i++) acc(1'b1, 1'b0, 8'hc3 + 8'(i), 8'h12 + 8'(i * 34), 1'b1, 8'h00);
    i_lpw_host_model.enter(32'h1234_5678);
    for (int i = 0; i < 4; i++) begin
      acc(1'b0, 1'b0, 8'hc3 + 8'(i), 8'h00, 1'b1, 8'h12 + 8'(i * 34));
    end
    i_lpw_host_model.enter(32'h1234_5600);
    for (int i = 0; i < 4; i++) acc(1'b0, 1'b0, 8'hc3 + 8'(i), 8'h00, 1'b1, 8'h00);
    // each enable bit alone: locked write refused inside, granted just outside
    foreach (blk[k]) begin
      {b, a, t, ia, oa} = blk[k];
      alt_map_i = a[1];
      acc(1'b1, 1'b0, 8'h7f, a[1] ? 8'h01 : 8'h04, 1'b1, 8'h00);
      i_lpw_host_model.enter(32'h1234_5678);
      acc(1'b1, 1'b0, 8'hc1, 8'h01 << b, 1'b1, 8'h00);
      acc(1'b1, 1'b0, 8'h7f, t, 1'b1, 8'h00);
      i_lpw_host_model.enter(32'h0000_0000);
      acc(1'b1, a[0], ia, ~ini(ia), 1'b0, 8'h00);
      acc(1'b1, a[0], oa, ini(oa), 1'b1, 8'h00);
      acc(1'b0, a[0], ia, 8'h00, 1'b1, ini(ia));
    end
    // read guard on lower memory
    alt_map_i = 1'b0;
    acc(1'b1, 1'b0, 8'h7f, 8'h04, 1'b1, 8'h00);
    i_lpw_host_model.enter(32'h1234_5678);
    acc(1'b1, 1'b0, 8'hc1, 8'h00, 1'b1, 8'h00);
    acc(1'b1, 1'b0, 8'hc2, 8'h04, 1'b1, 8'h00);
    i_lpw_host_model.enter(32'h1234_0000);
    acc(1'b0, 1'b0, 8'h7a, 8'h00, 1'b0, 8'h00);
    acc(1'b1, 1'b0, 8'h7a, ini(8'h7a), 1'b1, 8'h00);
    i_lpw_host_model.enter(32'h1234_5678);
    acc(1'b0, 1'b0, 8'h7a, 8'h00, 1'b1, ini(8'h7a));
    // select default byte, write-only entry bytes, readable select byte
    acc(1'b1, 1'b0, 8'hc7, 8'h05, 1'b1, 8'h00);
    acc(1'b0, 1'b0, 8'hc7, 8'h00, 1'b1, 8'h05);
    acc(1'b0, 1'b0, 8'h7b, 8'h00, 1'b1, 8'h00);
    acc(1'b0, 1'b0, 8'h7f, 8'h00, 1'b1, 8'h04);
    // second reset in mid-run: settings return to defaults, select reloaded
    rstn_i = 1'b0;
    repeat (2) @(posedge clk_i);
    #1 rstn_i = 1'b1;
    repeat (2) @(posedge clk_i);
    chk(tbl_sel, 8'h01);
    acc(1'b1, 1'b0, 8'h7f, 8'h04, 1'b1, 8'h00);
    acc(1'b0, 1'b0, 8'hc2, 8'h00, 1'b1, 8'h00);
    acc(1'b0, 1'b0, 8'hc1, 8'h00, 1'b1, 8'h00);
    give_verdict();
  end
endmodule
`default_nettype wire
